/* File: include/bae_pkg.sv */
// Purpose: Shared constants, types and helpers of the beam area evaluator
// Assumes: One 100 MHz clock, AXI4-Lite register access with 32-bit data
// Notes: Register byte address is four times the register index
package bae_pkg;

  // Clock and beam array geometry
  localparam int CLK_PERIOD_NS = 10;
  localparam int BEAMS = 1774;
  localparam int BEAM_W = 11;
  localparam int AREAS = 32;
  localparam int REC_W = 112;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // Field positions inside one area record
  localparam int F_EN = 104;
  localparam int F_POL = 96;
  localparam int F_START = 80;
  localparam int F_END = 64;
  localparam int F_ON = 48;
  localparam int F_OFF = 32;
  localparam int F_MID = 16;
  localparam int F_WID = 0;

  // Dynamic beam selector codes
  localparam logic [15:0] SEL_FIRST_DARK = 16'hfffe;
  localparam logic [15:0] SEL_FIRST_CLEAR = 16'hfffd;
  localparam logic [15:0] SEL_LAST_DARK = 16'hfffc;
  localparam logic [15:0] SEL_LAST_CLEAR = 16'hfffb;
  localparam logic [15:0] SEL_TARGET_MIN = 16'hfffa;

  // Largest beam count a middle or width field may hold
  localparam logic [15:0] BEAM_MAX = 16'h06ee;

  // Reset values
  localparam logic [15:0] RST_SEL = 16'h0001;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [REC_W-1:0] REC_RESET = {RST_FLAG, RST_FLAG, RST_SEL,
    RST_SEL, RST_CNT, RST_CNT, RST_CNT, RST_CNT};

  // Register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_SLICE_SEL = 10'h000;
  localparam logic [IDX_W-1:0] IDX_TARGET_MIN = 10'h001;
  localparam logic [IDX_W-1:0] IDX_SCAN_STATUS = 10'h002;
  localparam logic [IDX_W-1:0] IDX_AREA01 = 10'h064;
  localparam logic [IDX_W-1:0] IDX_AREA32 = 10'h083;
  localparam logic [IDX_W-1:0] IDX_FIRST_DARK = 10'h096;
  localparam logic [IDX_W-1:0] IDX_FIRST_CLEAR = 10'h097;
  localparam logic [IDX_W-1:0] IDX_LAST_DARK = 10'h098;
  localparam logic [IDX_W-1:0] IDX_LAST_CLEAR = 10'h099;
  localparam logic [IDX_W-1:0] IDX_DARK_TOTAL = 10'h09a;
  localparam logic [IDX_W-1:0] IDX_CLEAR_TOTAL = 10'h09b;
  localparam logic [IDX_W-1:0] IDX_RESULT_LO = 10'h09e;
  localparam logic [IDX_W-1:0] IDX_RESULT_HI = 10'h09f;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Scan sequencer states
  typedef enum logic [3:0] {
    BAE_SNAP = 4'b0001,
    BAE_FIND = 4'b0010,
    BAE_COUNT = 4'b0100,
    BAE_DONE = 4'b1000
  } bae_state_t;

  // Limit a beam count field to the array length
  function automatic logic [15:0] bae_clamp(input logic [15:0] v);
    return (v > BEAM_MAX) ? BEAM_MAX : v;
  endfunction : bae_clamp

  // Turn a start or end selector into a logical beam number
  function automatic logic [15:0] bae_resolve(input logic [15:0] sel,
      input logic [15:0] fd, input logic [15:0] fc, input logic [15:0] ld,
      input logic [15:0] lc, input logic [15:0] tm);
    case (sel)
      SEL_FIRST_DARK: return fd;
      SEL_FIRST_CLEAR: return fc;
      SEL_LAST_DARK: return ld;
      SEL_LAST_CLEAR: return lc;
      SEL_TARGET_MIN: return tm;
      default: return sel;
    endcase
  endfunction : bae_resolve

  // True for every index that the register map decodes
  function automatic logic bae_mapped(input logic [IDX_W-1:0] idx);
    return (idx <= IDX_SCAN_STATUS) ||
      (idx >= IDX_AREA01 && idx <= IDX_AREA32) ||
      (idx >= IDX_FIRST_DARK && idx <= IDX_CLEAR_TOTAL) ||
      (idx == IDX_RESULT_LO) || (idx == IDX_RESULT_HI);
  endfunction : bae_mapped

endpackage : bae_pkg

/* File: core/bae_evaluator.sv */
// Purpose: Area evaluation of a measuring light curtain, 32 areas
// Assumes: Beam states synchronous to aclk; AXI4-Lite master keeps protocol
// Notes: One full scan takes 2 * BEAMS + 2 cycles, results refresh per scan
`timescale 1ns/1ps
`default_nettype none

module bae_evaluator (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [bae_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [bae_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receiver beam states, bit i is logical beam i+1, 1 means interrupted
  input wire logic [bae_pkg::BEAMS-1:0] beam_dark,
  // Area results and scan completion
  output logic [bae_pkg::AREAS-1:0] area_result,
  output logic scan_done
);
  import bae_pkg::*;

  // Configuration storage, one record per area
  logic [REC_W-1:0] cfg [AREAS];
  logic [1:0] slice_sel; // Which 32-bit slice of a record is visible
  logic [15:0] target_min; // Position used by the target minimum code
  logic [31:0] scan_count; // Completed scans, free running

  // Scan sequencer
  bae_state_t state;
  logic [BEAM_W-1:0] bidx; // Beam under test, zero based
  logic [BEAMS-1:0] snap; // Beam states frozen for one whole scan
  logic [15:0] w_fd, w_fc, w_ld, w_lc, w_dt, w_ct; // Find pass working set
  logic [15:0] first_dark_beam, first_clear_beam; // Published positions
  logic [15:0] last_dark_beam, last_clear_beam;
  logic [15:0] dark_beam_total, clear_beam_total;
  logic [BEAM_W-1:0] acc [AREAS]; // Active beams counted per area
  logic [15:0] rs [AREAS]; // Resolved start beam
  logic [15:0] re [AREAS]; // Resolved end beam
  logic last_beam; // Final beam of a pass
  logic [15:0] beam_no; // Logical number of the beam under test
  logic cur_dark; // State of the beam under test
  logic [BEAM_W-1:0] find_len; // Helper: cycles spent so far in find pass

  // Bus side decode
  logic wr_fire, rd_fire;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [4:0] wr_area, rd_area;
  logic [127:0] next_wide;
  logic [REC_W-1:0] next_rec;
  logic [31:0] next_rdata;

  assign last_beam = (bidx == BEAM_W'(BEAMS - 1));
  assign beam_no = 16'(bidx) + 16'h0001;
  assign cur_dark = snap[bidx];

  // Write channels are taken together, only while no response waits
  assign s_axi_awready = s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready = s_axi_awvalid & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_idx = s_axi_awaddr[ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign wr_area = 5'(wr_idx - IDX_AREA01);
  assign rd_area = 5'(rd_idx - IDX_AREA01);

  // Merge the written slice into the addressed record
  always_comb begin
    next_wide = {16'h0000, cfg[wr_area]};
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b]) begin
        next_wide[32*slice_sel + 8*b +: 8] = s_axi_wdata[8*b +: 8];
      end
    end
    next_rec = next_wide[REC_W-1:0];
    next_rec[F_MID +: 16] = bae_clamp(next_wide[F_MID +: 16]);
    next_rec[F_WID +: 16] = bae_clamp(next_wide[F_WID +: 16]);
  end

  // Register writes; read-only and status indices ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < AREAS; k++) begin
        cfg[k] <= REC_RESET;
      end
      slice_sel <= 2'h0;
      target_min <= 16'h0000;
    end else if (wr_fire) begin
      if (wr_idx >= IDX_AREA01 && wr_idx <= IDX_AREA32) begin
        cfg[wr_area] <= next_rec;
      end else if (wr_idx == IDX_SLICE_SEL && s_axi_wstrb[0]) begin
        slice_sel <= s_axi_wdata[1:0];
      end else if (wr_idx == IDX_TARGET_MIN) begin
        if (s_axi_wstrb[0]) target_min[7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) target_min[15:8] <= s_axi_wdata[15:8];
      end
    end
  end

  // Write response, unmapped indices answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bae_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read multiplexer; record slices above bit 111 read as zero
  always_comb begin
    logic [127:0] rd_wide;
    rd_wide = {16'h0000, cfg[rd_area]};
    next_rdata = 32'h0000_0000;
    if (rd_idx >= IDX_AREA01 && rd_idx <= IDX_AREA32) begin
      next_rdata = rd_wide[32*slice_sel +: 32];
    end else begin
      case (rd_idx)
        IDX_SLICE_SEL: next_rdata = {30'h0, slice_sel};
        IDX_TARGET_MIN: next_rdata = {16'h0000, target_min};
        IDX_SCAN_STATUS: next_rdata = scan_count;
        IDX_FIRST_DARK: next_rdata = {16'h0000, first_dark_beam};
        IDX_FIRST_CLEAR: next_rdata = {16'h0000, first_clear_beam};
        IDX_LAST_DARK: next_rdata = {16'h0000, last_dark_beam};
        IDX_LAST_CLEAR: next_rdata = {16'h0000, last_clear_beam};
        IDX_DARK_TOTAL: next_rdata = {16'h0000, dark_beam_total};
        IDX_CLEAR_TOTAL: next_rdata = {16'h0000, clear_beam_total};
        IDX_RESULT_LO: next_rdata = {16'h0000, area_result[15:0]};
        IDX_RESULT_HI: next_rdata = {16'h0000, area_result[31:16]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read response, data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= bae_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sequencer: snapshot, find pass, count pass, publish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= BAE_SNAP;
      bidx <= '0;
    end else begin
      case (state)
        BAE_SNAP: begin
          bidx <= '0;
          state <= BAE_FIND;
        end
        BAE_FIND: begin
          bidx <= last_beam ? '0 : bidx + 1'b1;
          if (last_beam) state <= BAE_COUNT;
        end
        BAE_COUNT: begin
          bidx <= last_beam ? '0 : bidx + 1'b1;
          if (last_beam) state <= BAE_DONE;
        end
        BAE_DONE: state <= BAE_SNAP;
        default: state <= BAE_SNAP;
      endcase
    end
  end

  // Beam snapshot keeps both passes on the same picture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap <= '0;
    end else if (state == BAE_SNAP) begin
      snap <= beam_dark;
    end
  end

  // Find pass; zero means no such beam in this scan
  always_ff @(posedge aclk) begin
    if (!aresetn || state == BAE_SNAP) begin
      {w_fd, w_fc, w_ld, w_lc, w_dt, w_ct} <= '0;
    end else if (state == BAE_FIND) begin
      if (cur_dark) begin
        if (w_fd == 16'h0000) w_fd <= beam_no;
        w_ld <= beam_no;
        w_dt <= w_dt + 16'h0001;
      end else begin
        if (w_fc == 16'h0000) w_fc <= beam_no;
        w_lc <= beam_no;
        w_ct <= w_ct + 16'h0001;
      end
    end
  end

  // Publish positions; they stay fixed during the count pass
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_dark_beam <= 16'h0000;
      first_clear_beam <= 16'h0000;
      last_dark_beam <= 16'h0000;
      last_clear_beam <= 16'h0000;
      dark_beam_total <= 16'h0000;
      clear_beam_total <= 16'h0000;
    end else if (state == BAE_FIND && last_beam) begin
      first_dark_beam <= (w_fd == 16'h0000 && cur_dark) ? beam_no : w_fd;
      first_clear_beam <= (w_fc == 16'h0000 && !cur_dark) ? beam_no : w_fc;
      last_dark_beam <= cur_dark ? beam_no : w_ld;
      last_clear_beam <= cur_dark ? w_lc : beam_no;
      dark_beam_total <= w_dt + 16'(cur_dark);
      clear_beam_total <= w_ct + 16'(!cur_dark);
    end
  end

  // Resolve each area's range from its selectors
  always_comb begin
    for (int k = 0; k < AREAS; k++) begin
      rs[k] = bae_resolve(cfg[k][F_START +: 16], first_dark_beam,
        first_clear_beam, last_dark_beam, last_clear_beam, target_min);
      re[k] = bae_resolve(cfg[k][F_END +: 16], first_dark_beam,
        first_clear_beam, last_dark_beam, last_clear_beam, target_min);
    end
  end

  // Count pass; an inverted range counts nothing
  always_ff @(posedge aclk) begin
    for (int k = 0; k < AREAS; k++) begin
      if (!aresetn || state == BAE_SNAP) begin
        acc[k] <= '0;
      end else if (state == BAE_COUNT && beam_no >= rs[k] &&
          beam_no <= re[k]) begin
        if (cur_dark == cfg[k][F_POL]) acc[k] <= acc[k] + 1'b1;
      end
    end
  end

  // Result update with hysteresis; ON wins if both thresholds match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      area_result <= '0;
    end else if (state == BAE_DONE) begin
      for (int k = 0; k < AREAS; k++) begin
        if (cfg[k][F_EN +: 8] != 8'h01) begin
          area_result[k] <= 1'b0;
        end else if (16'(acc[k]) >= cfg[k][F_ON +: 16]) begin
          area_result[k] <= 1'b1;
        end else if (16'(acc[k]) <= cfg[k][F_OFF +: 16]) begin
          area_result[k] <= 1'b0;
        end
      end
    end
  end

  // Completion pulse and scan counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_done <= 1'b0;
      scan_count <= 32'h0000_0000;
    end else begin
      scan_done <= (state == BAE_DONE);
      if (state == BAE_DONE) scan_count <= scan_count + 32'h0000_0001;
    end
  end

  // Find pass length, counted so the check needs no long repetition
  always_ff @(posedge aclk) begin
    find_len <= (!aresetn || state != BAE_FIND) ? '0 : find_len + 1'b1;
  end

  // Bus answers one cycle after the handshake, read hold, find pass length
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && s_axi_bresp ==
      (bae_mapped($past(wr_idx)) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response missing");
  rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  lo_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_idx == IDX_RESULT_LO |=>
      s_axi_rdata == {16'h0000, $past(area_result[15:0])})
    else $error("low result word wrong");
  scan_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BAE_FIND |=>
      (state == BAE_COUNT) == (find_len == BEAM_W'(BEAMS)))
    else $error("find pass length wrong");

  // Per-area checks
  for (genvar g = 0; g < AREAS; g++) begin : g_chk
    on_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == BAE_DONE && cfg[g][F_EN +: 8] == 8'h01 &&
        16'(acc[g]) >= cfg[g][F_ON +: 16] |=> area_result[g])
      else $error("area did not switch on");
    off_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == BAE_DONE && 16'(acc[g]) < cfg[g][F_ON +: 16] &&
        16'(acc[g]) <= cfg[g][F_OFF +: 16] |=> !area_result[g])
      else $error("area did not switch off");
    hyst_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == BAE_DONE && cfg[g][F_EN +: 8] == 8'h01 &&
        16'(acc[g]) < cfg[g][F_ON +: 16] &&
        16'(acc[g]) > cfg[g][F_OFF +: 16] |=> $stable(area_result[g]))
      else $error("result changed inside hysteresis");
    disabled_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == BAE_DONE && cfg[g][F_EN +: 8] != 8'h01 |=> !area_result[g])
      else $error("disabled area reports one");
    clamp_mid_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg[g][F_MID +: 16] <= BEAM_MAX && cfg[g][F_WID +: 16] <= BEAM_MAX)
      else $error("middle or width above limit");
    dyn_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg[g][F_START +: 16] == SEL_FIRST_DARK |-> rs[g] == first_dark_beam)
      else $error("first dark selector not resolved");
    dyn_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg[g][F_END +: 16] == SEL_TARGET_MIN |-> re[g] == target_min)
      else $error("target selector not resolved");
    pol_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == BAE_COUNT && cur_dark != cfg[g][F_POL] &&
        !$changed(cfg[g]) |=> $stable(acc[g]))
      else $error("inactive beam was counted");
  end

endmodule : bae_evaluator

`default_nettype wire

/* File: sim/bae_beam_model.sv */
// Purpose: Optical receiver stand-in that drives the beam states
// Assumes: A new pattern lands right after a rising edge
// Notes: One contiguous dark run per pattern, all other beams clear
`timescale 1ns/1ps
`default_nettype none

module bae_beam_model (
  // Clock
  input wire logic aclk,
  // Beam states, bit i is logical beam i+1, 1 means interrupted
  output logic [bae_pkg::BEAMS-1:0] beam_dark
);
  import bae_pkg::*;

  // All paths free until the bench asks for a pattern
  initial begin
    beam_dark = '0;
  end

  // logical beam numbers
  // Positions are logical, so the run needs no remapping here
  task automatic set_dark(input int lo, input int hi);
    logic [BEAMS-1:0] pat;
    pat = '0;
    for (int b = 1; b <= BEAMS; b++) begin
      pat[b-1] = (b >= lo && b <= hi);
    end
    @(posedge aclk);
    beam_dark <= pat;
  endtask : set_dark

endmodule : bae_beam_model

`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench of the beam area evaluator
// Assumes: Register reads and writes go through AXI4-Lite tasks
// Notes: Each stage waits two scans so a half-seen pattern never counts
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import bae_pkg::*;

  // Clock, reset and bus
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, scan_done;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, area_result;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [BEAMS-1:0] beam_dark;
  // Expected answers, oldest first
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int num_errors, samples_checked, cycles, lo, len, hi;

  bae_evaluator u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .beam_dark(beam_dark),
    .area_result(area_result), .scan_done(scan_done));

  bae_beam_model u_beam (.aclk(aclk), .beam_dark(beam_dark));

  // Free-running clock
  always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  // Write: address and data offered together, held until taken
  task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [31:0] d,
      input logic [1:0] resp);
    wr_q.push_back(resp);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  // Read: address held until taken, rready held until the answer
  task automatic axi_rd(input logic [IDX_W-1:0] idx, input logic [31:0] d,
      input logic [1:0] resp);
    rd_q.push_back({resp, d});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // Area record through the slice window: flags, selectors, thresholds
  task automatic cfg(input int area, input logic [7:0] en,
      input logic [7:0] pol, input logic [15:0] s, input logic [15:0] e,
      input logic [15:0] on_t, input logic [15:0] off_t);
    logic [IDX_W-1:0] ai;
    ai = IDX_AREA01 + IDX_W'(area - 1);
    axi_wr(IDX_SLICE_SEL, 32'h3, RESP_OKAY);
    axi_wr(ai, {16'h0, en, pol}, RESP_OKAY);
    axi_wr(IDX_SLICE_SEL, 32'h2, RESP_OKAY);
    axi_wr(ai, {s, e}, RESP_OKAY);
    axi_wr(IDX_SLICE_SEL, 32'h1, RESP_OKAY);
    axi_wr(ai, {on_t, off_t}, RESP_OKAY);
  endtask : cfg

  // New beam pattern, the scan under way plus one whole scan, then port and result words
  task automatic stage(input int l, input int h, input logic [31:0] exp);
    u_beam.set_dark(l, h);
    repeat (2) begin
      @(posedge aclk);
      while (scan_done !== 1'b1) @(posedge aclk);
    end
    check(area_result === exp, "area result port");
    axi_rd(IDX_RESULT_LO, {16'h0, exp[15:0]}, RESP_OKAY);
    axi_rd(IDX_RESULT_HI, {16'h0, exp[31:16]}, RESP_OKAY);
  endtask : stage

  // Answers are compared with the oldest note as they appear
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check(rd_q.size() > 0 && {rresp, rdata} === rd_q.pop_front(),
        "read data or response");
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check(wr_q.size() > 0 && bresp === wr_q.pop_front(),
        "write response");
    end
  end

  // Hang guard, well above four stages of two scans each
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    void'($urandom(32'h7819faa3));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset image of the first and last records, slice by slice
    for (int s = 0; s < 4; s++) begin
      axi_wr(IDX_SLICE_SEL, 32'(s), RESP_OKAY);
      axi_rd(IDX_AREA01, (s == 2) ? 32'h00010001 : 32'h0, RESP_OKAY);
      axi_rd(IDX_AREA32, (s == 2) ? 32'h00010001 : 32'h0, RESP_OKAY);
    end
    // Middle one above the limit, width exactly at it
    axi_wr(IDX_SLICE_SEL, 32'h0, RESP_OKAY);
    axi_wr(IDX_AREA01, 32'h06ef06ee, RESP_OKAY);
    axi_rd(IDX_AREA01, 32'h06ee06ee, RESP_OKAY);
    // Unmapped place refuses both ways
    axi_rd(10'h3ff, 32'h0, RESP_SLVERR);
    axi_wr(10'h3ff, 32'h1, RESP_SLVERR);
    cfg(1, 8'h1, 8'h1, 16'd1, 16'd10, 16'd5, 16'd2);
    cfg(2, 8'h1, 8'h0, 16'd1, 16'd10, 16'd8, 16'd3);
    cfg(17, 8'h0, 8'h0, 16'd1, 16'd1774, 16'd0, 16'd0);
    cfg(18, 8'h1, 8'h0, 16'd1, 16'd1774, 16'd0, 16'd0);
    stage(1, 6, 32'h00020003);
    stage(1, 3, 32'h00020003);
    stage(1, 2, 32'h00020002);
    // Random dark run for the dynamic selectors
    lo = 20 + $urandom % 880;
    len = 1 + $urandom % 16;
    hi = lo + len - 1;
    cfg(3, 8'h1, 8'h1, SEL_FIRST_DARK, SEL_LAST_DARK, 16'(len),
      16'(len - 1));
    cfg(4, 8'h1, 8'h0, SEL_FIRST_CLEAR, SEL_LAST_CLEAR, 16'(BEAMS - len),
      16'(BEAMS - len - 1));
    axi_wr(IDX_TARGET_MIN, 32'(lo), RESP_OKAY);
    cfg(5, 8'h1, 8'h1, SEL_TARGET_MIN, 16'(hi), 16'(len),
      16'(len - 1));
    cfg(6, 8'h1, 8'h0, SEL_TARGET_MIN, SEL_TARGET_MIN, 16'd1,
      16'd0);
    stage(lo, hi, 32'h0002001e);
    axi_rd(IDX_FIRST_DARK, 32'(lo), RESP_OKAY);
    axi_rd(IDX_LAST_DARK, 32'(hi), RESP_OKAY);
    axi_rd(IDX_FIRST_CLEAR, 32'h1, RESP_OKAY);
    axi_rd(IDX_LAST_CLEAR, 32'(BEAMS), RESP_OKAY);
    axi_rd(IDX_DARK_TOTAL, 32'(len), RESP_OKAY);
    axi_rd(IDX_CLEAR_TOTAL, 32'(BEAMS - len), RESP_OKAY);
    // Read-only word keeps its value after a write
    axi_wr(IDX_FIRST_DARK, 32'h5, RESP_OKAY);
    axi_rd(IDX_FIRST_DARK, 32'(lo), RESP_OKAY);
    summarize();
  end

endmodule : testbench

`default_nettype wire
